// file: shared/bacr_pkg.sv
// bus area control register: constants, field layout, carriers
// assumes a 16-bit control word behind a 32-bit Avalon-MM slave
package bacr_pkg;

   // ***************************************************************
   // bus and register map
   // ***************************************************************
   localparam int unsigned DATA_W   = 32;
   localparam int unsigned ADDR_W   = 8;
   localparam int unsigned REG_W    = 16;
   localparam logic [7:0]  CTL1_OFS = 8'h00;
   localparam logic [15:0] CTL1_RST = 16'h0000;
   localparam logic [15:0] RW_MASK  = 16'hf7ff;

   // ***************************************************************
   // field positions
   // ***************************************************************
   localparam int unsigned B_ADDR_PU  = 15;
   localparam int unsigned B_DATA_PU  = 14;
   localparam int unsigned B_MEM_HOLD = 13;
   localparam int unsigned B_STRB_DRV = 12;
   localparam int unsigned B_ENDIAN = 11;
   localparam int unsigned A0BST_LO = 9;
   localparam int unsigned A5BST_LO = 7;
   localparam int unsigned A6BST_LO = 5;
   localparam int unsigned MTYPE_LO = 2;
   localparam int unsigned B_A5CARD = 1;
   localparam int unsigned B_A6CARD = 0;

   // ***************************************************************
   // codes and counts
   // ***************************************************************
   localparam logic [4:0] BL_NONE  = 5'h00;
   localparam logic [4:0] BL_4     = 5'h04;
   localparam logic [4:0] BL_8     = 5'h08;
   localparam logic [4:0] BL_16    = 5'h10;
   localparam logic [2:0] MT_PLAIN = 3'h0;
   localparam logic [2:0] MT_MIXED = 3'h2;
   localparam logic [2:0] MT_SDRAM = 3'h3;
   localparam logic [2:0] PULLUP_CYC = 3'h4;
   localparam logic [1:0] MODE_CAP_DLY = 2'h2;

   typedef enum logic [1:0] {
      BACR_ST_IDLE = 2'b01,
      BACR_ST_ANS  = 2'b10
   } bacr_bus_st_t;

   typedef struct packed {
      logic addr_pullup;
      logic data_pullup;
      logic mem_high;
      logic mem_float;
      logic strobe_float;
   } bacr_pins_t;

   typedef struct packed {
      logic       little_endian;
      logic [4:0] area0_burst;
      logic [4:0] area5_burst;
      logic [4:0] area6_burst;
      logic       area2_sdram;
      logic       area3_sdram;
      logic       mem_type_bad;
      logic       area5_card;
      logic       area6_card;
   } bacr_cfg_t;

endpackage : bacr_pkg

// file: hw/bacr_top.sv
// bus area control register with pin-state and area-config outputs
// assumes side inputs come from logic on clock_in; mode pin is async
//
// The implementer's own choices: the address map and the Avalon-MM interface to the registers.
`timescale 1ns/100ps
`default_nettype none

module bacr_top
   import bacr_pkg::*;
(
   input  wire logic              clock_in,
   input  wire logic              resetn_in,
   input  wire logic [ADDR_W-1:0] avs_address_in,
   input  wire logic              avs_read_in,
   input  wire logic              avs_write_in,
   input  wire logic [DATA_W-1:0] avs_writedata_in,
   input  wire logic [3:0]        avs_byteenable_in,
   output logic [DATA_W-1:0]      avs_readdata_out,
   output logic                   avs_waitrequest_out,
   input  wire logic              mode_pin_in,
   input  wire logic              bus_ack_in,
   input  wire logic              data_idle_in,
   input  wire logic              standby_in,
   input  wire logic              bus_released_in,
   output bacr_pins_t             pins_out,
   output bacr_cfg_t              cfg_out
);

   // ***************************************************************
   // state
   // ***************************************************************
   typedef struct packed {
      bacr_bus_st_t      st;
      logic              waitreq;
      logic [DATA_W-1:0] rdata;
      logic [REG_W-1:0]  ctl;
      logic              mode_s1;
      logic              mode_s2;
      logic [1:0]        cap_cnt;
      logic              cap_done;
      logic              ack_d;
      logic [2:0]        pu_cnt;
      bacr_pins_t        pins;
      bacr_cfg_t         cfg;
   } bacr_state_t;

   localparam bacr_state_t S_RST = '{
      st:      BACR_ST_IDLE,
      waitreq: 1'b1,
      ctl:     CTL1_RST,
      default: '0
   };

   logic        rst_s1_r;
   logic        rst_n_r;
   bacr_state_t s_r;
   bacr_state_t s_nxt;

   // ***************************************************************
   // helpers
   // ***************************************************************
   function automatic logic [4:0] burst_len(input logic [1:0] code);
      logic [4:0] len;
      len = BL_NONE;
      unique case (code)
         2'b00: len = BL_NONE;
         2'b01: len = BL_4;
         2'b10: len = BL_8;
         2'b11: len = BL_16;
      endcase
      return len;
   endfunction : burst_len

   function automatic logic [15:0] lane_mask(input logic [3:0] be);
      return {{8{be[1]}}, {8{be[0]}}};
   endfunction : lane_mask

   // ***************************************************************
   // reset release
   // ***************************************************************
   always_ff @(posedge clock_in or negedge resetn_in) begin
      if (!resetn_in) begin
         rst_s1_r <= 1'b0;
         rst_n_r  <= 1'b0;
      end else begin
         rst_s1_r <= 1'b1;
         rst_n_r  <= rst_s1_r;
      end
   end

   // ***************************************************************
   // next state
   // ***************************************************************
   logic        req;
   logic        hit;
   logic [15:0] wmask;
   logic [2:0]  mtype;

   assign req   = avs_read_in | avs_write_in;
   assign hit   = (avs_address_in == CTL1_OFS);
   assign wmask = lane_mask(avs_byteenable_in) & RW_MASK;
   assign mtype = s_r.ctl[MTYPE_LO +: 3];

   always_comb begin
      s_nxt = s_r;
      s_nxt.mode_s1 = mode_pin_in;
      s_nxt.mode_s2 = s_r.mode_s1;

      // bus slave, one wait cycle per access
      unique case (s_r.st)
         BACR_ST_IDLE: begin
            if (req) begin
               s_nxt.st      = BACR_ST_ANS;
               s_nxt.waitreq = 1'b0;
               s_nxt.rdata   = hit ? {16'h0000, s_r.ctl} : '0;
            end
         end
         BACR_ST_ANS: begin
            s_nxt.st      = BACR_ST_IDLE;
            s_nxt.waitreq = 1'b1;
            if (avs_write_in && hit) begin
               // writable fields of the enabled byte lanes in one edge
               s_nxt.ctl = (s_r.ctl & ~wmask)
                         | (avs_writedata_in[15:0] & wmask);
            end
         end
      endcase

      // byte order caught once after reset release
      if (!s_r.cap_done) begin
         if (s_r.cap_cnt == MODE_CAP_DLY) begin
            s_nxt.ctl[B_ENDIAN] = s_r.mode_s2;
            s_nxt.cap_done      = 1'b1;
         end else begin
            s_nxt.cap_cnt = s_r.cap_cnt + 2'd1;
         end
      end

      // address pull-up window after acknowledge rises
      s_nxt.ack_d = bus_ack_in;
      if (bus_ack_in && !s_r.ack_d) begin
         s_nxt.pu_cnt = PULLUP_CYC;
      end else if (s_r.pu_cnt != 3'd0) begin
         s_nxt.pu_cnt = s_r.pu_cnt - 3'd1;
      end
      s_nxt.pins.addr_pullup = s_r.ctl[B_ADDR_PU]
                             && (s_nxt.pu_cnt != 3'd0);
      s_nxt.pins.data_pullup = s_r.ctl[B_DATA_PU]
                             && data_idle_in;
      s_nxt.pins.mem_high  = standby_in && s_r.ctl[B_MEM_HOLD];
      s_nxt.pins.mem_float = standby_in && !s_r.ctl[B_MEM_HOLD];
      s_nxt.pins.strobe_float = (standby_in || bus_released_in)
                              && !s_r.ctl[B_STRB_DRV];

      // area configuration decode
      s_nxt.cfg.little_endian = s_r.ctl[B_ENDIAN];
      s_nxt.cfg.area0_burst =
         burst_len(s_r.ctl[A0BST_LO +: 2]);
      s_nxt.cfg.area5_burst =
         burst_len(s_r.ctl[A5BST_LO +: 2]);
      s_nxt.cfg.area6_burst =
         burst_len(s_r.ctl[A6BST_LO +: 2]);
      s_nxt.cfg.area2_sdram  = (mtype == MT_SDRAM);
      s_nxt.cfg.area3_sdram  = (mtype == MT_SDRAM)
                             || (mtype == MT_MIXED);
      s_nxt.cfg.mem_type_bad = (mtype != MT_PLAIN)
                             && (mtype != MT_MIXED)
                             && (mtype != MT_SDRAM);
      s_nxt.cfg.area5_card = s_r.ctl[B_A5CARD];
      s_nxt.cfg.area6_card = s_r.ctl[B_A6CARD];
   end

   // ***************************************************************
   // registers
   // ***************************************************************
   always_ff @(posedge clock_in or negedge rst_n_r) begin
      if (!rst_n_r) begin
         s_r <= S_RST;
      end else begin
         s_r <= s_nxt;
      end
   end

   assign avs_readdata_out    = s_r.rdata;
   assign avs_waitrequest_out = s_r.waitreq;
   assign pins_out            = s_r.pins;
   assign cfg_out             = s_r.cfg;

   // ***************************************************************
   // checks
   // ***************************************************************
   default clocking cb @(posedge clock_in);
   endclocking
   default disable iff (!rst_n_r);

   a_bus_answer: assert property (
      (req && s_r.st == BACR_ST_IDLE)
         |=> !avs_waitrequest_out ##1 avs_waitrequest_out)
      else $error("waitrequest did not answer in one cycle");

   a_reg_hold: assert property (
      (s_r.cap_done && !(s_r.st == BACR_ST_ANS && avs_write_in))
         |=> $stable(s_r.ctl))
      else $error("control word changed without a write");

   a_write_all: assert property (
      (s_r.st == BACR_ST_ANS && avs_write_in && hit
         && avs_byteenable_in[1:0] == 2'b11)
         |=> ((s_r.ctl & RW_MASK)
              == ($past(avs_writedata_in[15:0]) & RW_MASK)))
      else $error("write did not update every field");

   a_endian_ro: assert property (
      s_r.cap_done |=> $stable(s_r.ctl[B_ENDIAN]))
      else $error("byte-order flag changed after capture");

   a_pullup_len: assert property (
      (bus_ack_in && !s_r.ack_d && s_r.ctl[B_ADDR_PU])
         ##1 s_r.ctl[B_ADDR_PU] [*3]
         |=> pins_out.addr_pullup
             && $past(pins_out.addr_pullup)
             && $past(pins_out.addr_pullup, 2)
             && $past(pins_out.addr_pullup, 3))
      else $error("address pull-up shorter than four cycles");

   a_pullup_off: assert property (
      !s_r.ctl[B_ADDR_PU] |=> !pins_out.addr_pullup)
      else $error("address pull-up while disabled");

   a_pullup_end: assert property (
      (s_r.pu_cnt == 3'd1 && !(bus_ack_in && !s_r.ack_d))
         |=> !pins_out.addr_pullup)
      else $error("address pull-up outlasted its window");

   a_data_pull: assert property (
      (data_idle_in && s_r.ctl[B_DATA_PU]) |=> pins_out.data_pullup)
      else $error("idle data pins not pulled up");

   a_standby_pins: assert property (
      (standby_in && s_r.ctl[B_MEM_HOLD])
         |=> pins_out.mem_high && !pins_out.mem_float)
      else $error("standby memory pins not held high");

   a_strobe_float: assert property (
      ((standby_in || bus_released_in) && !s_r.ctl[B_STRB_DRV])
         |=> pins_out.strobe_float)
      else $error("strobes driven while they should float");

   a_burst_area0: assert property (
      (s_r.ctl[A0BST_LO +: 2] == 2'b11)
         |=> cfg_out.area0_burst == BL_16)
      else $error("area 0 burst length wrong");

   a_burst_area5: assert property (
      (s_r.ctl[A5BST_LO +: 2] == 2'b10)
         |=> cfg_out.area5_burst == BL_8)
      else $error("area 5 burst length wrong");

   a_burst_area6: assert property (
      (s_r.ctl[A6BST_LO +: 2] == 2'b01)
         |=> cfg_out.area6_burst == BL_4)
      else $error("area 6 burst length wrong");

   a_mem_mixed: assert property (
      (mtype == MT_MIXED)
         |=> !cfg_out.area2_sdram && cfg_out.area3_sdram)
      else $error("mixed memory type decoded wrong");

   a_card_area5: assert property (
      s_r.ctl[B_A5CARD] |=> cfg_out.area5_card)
      else $error("area 5 card space not selected");

   a_card_area6: assert property (
      !s_r.ctl[B_A6CARD] |=> !cfg_out.area6_card)
      else $error("area 6 card space selected wrongly");

   a_mem_both: assert property (
      (mtype == MT_SDRAM)
         |=> cfg_out.area2_sdram && cfg_out.area3_sdram)
      else $error("both-SDRAM memory type decoded wrong");

   a_mem_plain: assert property (
      (mtype == MT_PLAIN)
         |=> !cfg_out.area2_sdram && !cfg_out.area3_sdram
             && !cfg_out.mem_type_bad)
      else $error("plain memory type decoded wrong");

   a_burst_plain: assert property (
      (s_r.ctl[A0BST_LO +: 2] == 2'b00)
         |=> cfg_out.area0_burst == BL_NONE)
      else $error("area 0 plain access decoded wrong");

   a_endian_out: assert property (
      s_r.ctl[B_ENDIAN] |=> cfg_out.little_endian)
      else $error("little-endian flag not shown on config");

endmodule : bacr_top

`default_nettype wire

// file: test/bacr_far_side.sv
// far-side bus model: acknowledge, data idle, standby and bus release signals for the design
// assumes it shares clock_in with the design and is stepped by the bench
`timescale 1ns/100ps
`default_nettype none

module bacr_far_side (
   input  wire logic clock_in,
   input  wire logic step_in,
   input  wire logic ack_req_in,
   output logic      bus_ack_out      = 1'b0,
   output logic      data_idle_out    = 1'b0,
   output logic      standby_out      = 1'b0,
   output logic      bus_released_out = 1'b0
);
   int seed = 53624;

   // every far-side memory is 8 bits wide, so each burst code is legal
   localparam int unsigned MEM_BUS_W = 8;
   // areas 2 and 3 share that one width
   // bus clock runs below the core clock, so mixed SDRAM is usable
   localparam int unsigned CLK_RATIO = 2;

   // ***************************************************************
   // bus state
   // ***************************************************************
   // idle, standby and release move only when stepped; acknowledge follows ack_req_in every clock
   always @(posedge clock_in) begin
      bus_ack_out <= ack_req_in;
      if (step_in) begin
         {data_idle_out, standby_out, bus_released_out} <= 3'($random(seed));
      end
   end
endmodule : bacr_far_side

`default_nettype wire

// file: test/bus_area_control_register_tb.sv
// bench for the bus area control register
// assumes bacr_pkg, bacr_top and bacr_far_side are compiled before it
`timescale 1ns/100ps
`default_nettype none

`define CHK(g, e) begin checked++; if ((g) !== (e)) begin fail_count++; \
   $display("mismatch t=%0t got=%h exp=%h", $time, g, e); end end

module bus_area_control_register_tb;
   import bacr_pkg::*;
   logic              clock_in = 1'b0;
   logic              resetn_in = 1'b0;
   logic [ADDR_W-1:0] addr = '0;
   logic              rd = 1'b0;
   logic              wr = 1'b0;
   logic [DATA_W-1:0] wdata = '0;
   logic [DATA_W-1:0] rdata;
   logic              wreq;
   logic              mode = 1'b1;
   logic              step = 1'b0;
   logic              ack_req = 1'b0;
   wire logic         ack;
   wire logic         idle;
   wire logic         stby;
   wire logic         rel;
   bacr_pins_t        pins;
   bacr_cfg_t         cfg;
   int                fail_count = 0;
   int                checked = 0;
   int                seed = 53624;
   int                hi;
   logic [15:0]       word;
   logic [31:0]       q;
   logic              done = 1'b0;
   logic              timed_out = 1'b0;
   bacr_cfg_t         ecfg;

   always #2.5 clock_in = ~clock_in;

   bacr_top dut (
      .clock_in(clock_in), .resetn_in(resetn_in),
      .avs_address_in(addr), .avs_read_in(rd), .avs_write_in(wr),
      .avs_writedata_in(wdata), .avs_byteenable_in(4'hf),
      .avs_readdata_out(rdata), .avs_waitrequest_out(wreq),
      .mode_pin_in(mode), .bus_ack_in(ack), .data_idle_in(idle),
      .standby_in(stby), .bus_released_in(rel),
      .pins_out(pins), .cfg_out(cfg)
   );

   bacr_far_side far (
      .clock_in(clock_in), .step_in(step), .ack_req_in(ack_req),
      .bus_ack_out(ack), .data_idle_out(idle), .standby_out(stby),
      .bus_released_out(rel)
   );

   // ***************************************************************
   // expectations
   // ***************************************************************
   function automatic logic [4:0] blen(input logic [1:0] c);
      return c == 2'd0 ? BL_NONE : c == 2'd1 ? BL_4 : c == 2'd2 ? BL_8 : BL_16;
   endfunction : blen

   function automatic bacr_cfg_t exp_cfg(input logic [15:0] w);
      logic [2:0] t;
      t = w[4:2];
      return '{w[11], blen(w[10:9]), blen(w[8:7]), blen(w[6:5]),
               t == MT_SDRAM, t == MT_SDRAM || t == MT_MIXED,
               !(t inside {MT_PLAIN, MT_MIXED, MT_SDRAM}), w[1], w[0]};
   endfunction : exp_cfg

   function automatic bacr_pins_t exp_pins(input logic [15:0] w);
      return '{1'b0, w[14] & idle, stby & w[13], stby & !w[13],
               (stby | rel) & !w[12]};
   endfunction : exp_pins

   // only the three permitted area 2/3 type codes are written
   function automatic logic [2:0] legal_type(input logic [1:0] r);
      return r == 2'd0 ? MT_PLAIN : r == 2'd1 ? MT_MIXED : MT_SDRAM;
   endfunction : legal_type

   // ***************************************************************
   // bus master and verdict
   // ***************************************************************
   task automatic print_verdict();
      $display("comparisons %0d mismatches %0d", checked, fail_count);
      if (fail_count == 0 && checked > 0) begin
         $display("Regression OK");
      end else begin
         $display("Regression broken");
      end
      $finish;
   endtask : print_verdict

   // request held until the edge that sees waitrequest low
   task automatic xfer(input logic w, input logic [7:0] a,
                       input logic [31:0] d);
      int n;
      n = 0;
      addr <= a;
      wdata <= d;
      wr <= w;
      rd <= !w;
      do begin
         @(posedge clock_in);
         n++;
      end while (wreq !== 1'b0 && n < 20);
      q = rdata;
      if (wreq !== 1'b0) begin
         timed_out = 1'b1;
      end
      rd <= 1'b0;
      wr <= 1'b0;
      @(posedge clock_in);
   endtask : xfer

   // ***************************************************************
   // main sequence: two power-on resets with each strap level
   // ***************************************************************
   initial begin
      for (int e = 1; e >= 0; e--) begin
         mode <= e[0];
         resetn_in <= 1'b0;
         repeat (8) @(posedge clock_in);
         resetn_in <= 1'b1;
         repeat (10) @(posedge clock_in);
         xfer(1'b0, CTL1_OFS, '0);
         `CHK(q, {20'h0, e[0], 11'h0})
         repeat (24) begin
            word = 16'($random(seed));
            word[MTYPE_LO +: 3] = legal_type(2'($random(seed)));
            xfer(1'b1, CTL1_OFS, {16'($random(seed)), word});
            word[B_ENDIAN] = e[0];
            xfer(1'b1, 8'h04, 32'($random(seed)));
            step <= 1'b1;
            @(posedge clock_in);
            step <= 1'b0;
            repeat (3) @(posedge clock_in);
            ecfg = exp_cfg(word);
            `CHK(cfg[20:5], ecfg[20:5])
            `CHK(cfg[4:0], ecfg[4:0])
            `CHK(pins, exp_pins(word))
            xfer(1'b0, CTL1_OFS, '0);
            `CHK(q, {16'h0, word})
            xfer(1'b0, 8'h04, '0);
            `CHK(q, 32'h0)
         end
         // address pull-up after bus acknowledge, on and off
         word[B_ADDR_PU] = e[0];
         xfer(1'b1, CTL1_OFS, {16'h0, word});
         repeat (3) @(posedge clock_in);
         ack_req <= 1'b1;
         hi = 0;
         repeat (10) begin
            @(posedge clock_in);
            if (pins.addr_pullup === 1'b1) hi++;
         end
         `CHK(hi, e ? 4 : 0)
         ack_req <= 1'b0;
      end
      done = 1'b1;
   end

   // single closing point: finished run, hung bus or cycle limit
   initial begin : closing
      int n;
      n = 0;
      while (!done && !timed_out && n < 20000) begin
         @(posedge clock_in);
         n++;
      end
      if (timed_out || !done) begin
         fail_count++;
      end
      print_verdict();
   end
endmodule : bus_area_control_register_tb

`default_nettype wire
